// ==== include/sfl_cfg.svh ====
// Register offsets, field positions, reset values and counts
`ifndef SFL_CFG_SVH
`define SFL_CFG_SVH

// ---------------------------------------------------------------
// Register offsets on the special-function register port
// ---------------------------------------------------------------
`define SFL_CTRL_ADDR      8'hC0
`define SFL_DATA_ADDR      8'hC2

// ---------------------------------------------------------------
// Control and status field positions
// ---------------------------------------------------------------
`define SFL_BIT_MASTER     7
`define SFL_BIT_TXDIR      6
`define SFL_BIT_START      5
`define SFL_BIT_STOP       4
`define SFL_BIT_ACKNEED    3
`define SFL_BIT_ARBFAIL    2
`define SFL_BIT_ACK        1
`define SFL_BIT_IRQ        0

// ---------------------------------------------------------------
// Reset values and counts
// ---------------------------------------------------------------
`define SFL_CTRL_RESET     8'h00
`define SFL_DATA_RESET     8'h00
`define SFL_BITS_PER_BYTE  4'h8

`endif

// ==== include/sfl_pkg.sv ====
// Types shared by the flag and data logic
package sfl_pkg;

   // Position within a byte frame on the wires
   typedef enum logic [1:0] {
      FR_IDLE,
      FR_BITS,
      FR_ACK
   } sfl_frame_t;

endpackage

// ==== hw/sfl_pin_sync.sv ====
// Bus pin synchroniser with start, stop and clock edge detection
`timescale 1ns/1ps
`include "sfl_cfg.svh"

module sfl_pin_sync
   import sfl_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic arst_n,
   // Raw bus pins
   input  wire logic scl_pin,
   input  wire logic sda_pin,
   // Synchronised levels and events
   output logic      scl,
   output logic      sda,
   output logic      scl_rise,
   output logic      scl_fall,
   output logic      start_det,
   output logic      stop_det
);

   logic scl_meta;
   logic sda_meta;
   logic scl_prev;
   logic sda_prev;

   // ---------------------------------------------------------------
   // Two-stage synchroniser, then one stage of history
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         scl_meta <= 1'b1;
         sda_meta <= 1'b1;
         scl      <= 1'b1;
         sda      <= 1'b1;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_meta <= scl_pin;
         sda_meta <= sda_pin;
         scl      <= scl_meta;
         sda      <= sda_meta;
         scl_prev <= scl;
         sda_prev <= sda;
      end
   end

   // ---------------------------------------------------------------
   // Edge and condition detection
   // ---------------------------------------------------------------
   assign scl_rise  = scl & ~scl_prev;
   assign scl_fall  = ~scl & scl_prev;
   assign start_det = scl & scl_prev & sda_prev & ~sda;
   assign stop_det  = scl & scl_prev & ~sda_prev & sda;

endmodule

// ==== hw/sfl_flags.sv ====
// Status flag update logic and serial byte register
`timescale 1ns/1ps
`include "sfl_cfg.svh"

// Summary of operation
// RULE_01: Role flag sets on own START, clears on own STOP or arbitration loss
// RULE_02: Tx flag sets on own START or early data write; START seen clears it
// RULE_03: Start flag sets on START plus address; only software clears it.
// RULE_04: Stop flag sets on slave STOP or STOP loss; clears once generated.
// RULE_05: Ack-needed flag sets on received byte, clears after each ack slot.
// RULE_06: Arbitration lost on stray restart, SCL low in condition, SDA clash
// RULE_07: Arbitration-fail flag clears when software clears interrupt flag.
// RULE_08: Ack bit is set by a low ack slot, cleared by a high one.
// RULE_09: Interrupt flag sets on each listed transfer event.
// RULE_10: Interrupt flag is cleared only by a software write.
// RULE_11: Serial byte holds last byte, stable while interrupt flag is set.
// RULE_12: Software touches serial byte only while interrupt flag is set.
// RULE_13: Bytes shift most significant bit first, in and out.
// RULE_14: Bus value is shifted back in while transmitting.
// RULE_15: Lost arbitration keeps the byte in the serial byte register.
// RULE_16: Serial byte register is 8 bits, read/write, at 0xC2, reset 0x00.
// RULE_17: SCL is held low while the interrupt flag is set.
// RULE_18: Control byte: role flag in bit 7 down to interrupt flag in bit 0.
// RULE_19: Writing 0 clears the interrupt flag; writing 1 forces it.
// RULE_20: Flags update on the clock; a hardware set beats a software clear.
module sfl_flags
   import sfl_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   // Special-function register port
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   // Events from the transfer sequencer
   input  wire logic       start_generated,
   input  wire logic       stop_generated,
   input  wire logic       scl_low_in_cond,
   input  wire logic       addr_match,
   // Bus pins, open drain
   input  wire logic       scl_in,
   output logic            scl_out,
   output logic            scl_oe_n,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   // Flags toward the sequencer
   output logic            master_flag,
   output logic            transmit_direction_flag,
   output logic            start_request_flag,
   output logic            stop_request_flag,
   output logic            ack_needed_flag,
   output logic            arbitration_fail_flag,
   output logic            ack_flag,
   output logic            irq_flag
);

   logic       scl;
   logic       sda;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;
   logic [7:0] serial_byte_data;
   logic [3:0] bit_cnt;
   logic       first_byte;
   logic       addressed;
   logic       data_written;
   sfl_frame_t frame;
   logic       ctrl_wr;
   logic       data_wr;
   logic       irq_clr;
   logic       live;
   logic       rise_bit;
   logic       rise_ack;
   logic       byte_done;
   logic       rx_addr_ok;
   logic       arb_set;
   logic       irq_set;
   logic       frame_begin;
   logic [7:0] ctrl_byte;

   sfl_pin_sync u_sync (
      .clk_sys   (clk_sys),
      .arst_n    (arst_n),
      .scl_pin   (scl_in),
      .sda_pin   (sda_in),
      .scl       (scl),
      .sda       (sda),
      .scl_rise  (scl_rise),
      .scl_fall  (scl_fall),
      .start_det (start_det),
      .stop_det  (stop_det)
   );

   // ---------------------------------------------------------------
   // Event decode
   // ---------------------------------------------------------------
   always_comb begin
      ctrl_wr     = sfr_wr && (sfr_addr == `SFL_CTRL_ADDR);
      data_wr     = sfr_wr && (sfr_addr == `SFL_DATA_ADDR);
      irq_clr     = ctrl_wr && !sfr_wdata[`SFL_BIT_IRQ];
      live        = !irq_flag && !start_det && !stop_det;
      rise_bit    = live && scl_rise && (frame == FR_BITS);
      rise_ack    = live && scl_rise && (frame == FR_ACK);
      byte_done   = rise_bit && (bit_cnt == `SFL_BITS_PER_BYTE - 4'h1);
      frame_begin = live && scl_fall && (frame == FR_IDLE) && !first_byte;
      rx_addr_ok  = first_byte && !master_flag && addr_match;
      arb_set     = scl_low_in_cond                                 // RULE_06
                 || (start_det && master_flag && !start_request_flag
                     && frame != FR_IDLE)                           // RULE_06
                 || (rise_bit && transmit_direction_flag
                     && serial_byte_data[7] && !sda)                // RULE_06
                 || (stop_det && master_flag && !stop_request_flag);
      irq_set     = start_generated                                 // RULE_09
                 || arb_set                                         // RULE_09
                 || (rise_ack && transmit_direction_flag
                     && (master_flag || addressed))                 // RULE_09
                 || (byte_done && !transmit_direction_flag
                     && (master_flag || addressed || rx_addr_ok))   // RULE_09
                 || (stop_det && addressed);                        // RULE_09
   end

   // ---------------------------------------------------------------
   // Byte frame tracking
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         frame      <= FR_IDLE;
         bit_cnt    <= 4'h0;
         first_byte <= 1'b0;
         addressed  <= 1'b0;
      end else if (start_det) begin
         frame      <= FR_BITS;
         bit_cnt    <= 4'h0;
         first_byte <= 1'b1;
         addressed  <= 1'b0;
      end else if (stop_det
                   || (arb_set && !master_flag && frame == FR_IDLE)) begin
         frame      <= FR_IDLE;
         bit_cnt    <= 4'h0;
         addressed  <= 1'b0;
      end else if (rise_bit) begin
         bit_cnt <= bit_cnt + 4'h1;
         if (byte_done) begin
            frame <= FR_ACK;
         end
      end else if (rise_ack) begin
         frame      <= FR_IDLE;
         bit_cnt    <= 4'h0;
         first_byte <= 1'b0;
      end else if (frame_begin) begin
         frame <= FR_BITS;
      end
      if (!start_det && !stop_det && byte_done && rx_addr_ok) begin
         addressed <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Serial byte register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         serial_byte_data <= `SFL_DATA_RESET;                    // RULE_16
      end else if (rise_bit) begin
         serial_byte_data <= {serial_byte_data[6:0], sda};       // RULE_13
      end else if (data_wr) begin
         serial_byte_data <= sfr_wdata;                          // RULE_16
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         data_written <= 1'b0;
      end else if (data_wr) begin
         data_written <= 1'b1;
      end else if (frame_begin || start_det) begin
         data_written <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Role and direction flags
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         master_flag <= 1'b0;
      end else if (start_generated) begin
         master_flag <= 1'b1;                                    // RULE_01
      end else if (stop_generated || arb_set) begin
         master_flag <= 1'b0;                                    // RULE_01
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         transmit_direction_flag <= 1'b0;
      end else if (start_generated) begin
         transmit_direction_flag <= 1'b1;                        // RULE_02
      end else if (start_det || arb_set) begin
         transmit_direction_flag <= 1'b0;                        // RULE_02
      end else if (frame_begin) begin
         transmit_direction_flag <= data_written;                // RULE_02
      end
   end

   // ---------------------------------------------------------------
   // Start, stop and acknowledge flags
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         start_request_flag <= 1'b0;
      end else if (byte_done && rx_addr_ok) begin
         start_request_flag <= 1'b1;                             // RULE_03
      end else if (ctrl_wr) begin
         start_request_flag <= sfr_wdata[`SFL_BIT_START];        // RULE_03
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         stop_request_flag <= 1'b0;
      end else if (stop_det && (addressed || master_flag)) begin
         stop_request_flag <= 1'b1;                              // RULE_04
      end else if (stop_generated) begin
         stop_request_flag <= 1'b0;                              // RULE_04
      end else if (ctrl_wr) begin
         stop_request_flag <= sfr_wdata[`SFL_BIT_STOP];
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ack_needed_flag <= 1'b0;
      end else if (byte_done && !transmit_direction_flag
                   && (master_flag || addressed || rx_addr_ok)) begin
         ack_needed_flag <= 1'b1;                                // RULE_05
      end else if (rise_ack || start_det || stop_det) begin
         ack_needed_flag <= 1'b0;                                // RULE_05
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ack_flag <= 1'b0;
      end else if (rise_ack && transmit_direction_flag) begin
         ack_flag <= !sda;                                       // RULE_08
      end else if (ctrl_wr) begin
         ack_flag <= sfr_wdata[`SFL_BIT_ACK];
      end
   end

   // ---------------------------------------------------------------
   // Interrupt and arbitration flags
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         irq_flag <= 1'b0;
      end else if (irq_set) begin
         irq_flag <= 1'b1;                                       // RULE_20
      end else if (ctrl_wr) begin
         irq_flag <= sfr_wdata[`SFL_BIT_IRQ];                    // RULE_19 RULE_10
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         arbitration_fail_flag <= 1'b0;
      end else if (arb_set) begin
         arbitration_fail_flag <= 1'b1;                          // RULE_06
      end else if (irq_clr) begin
         arbitration_fail_flag <= 1'b0;                          // RULE_07
      end
   end

   // ---------------------------------------------------------------
   // Bus drivers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         scl_out  <= 1'b0;
         scl_oe_n <= 1'b1;
      end else begin
         scl_out  <= 1'b0;
         scl_oe_n <= !(irq_flag || irq_set);                     // RULE_17
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sda_out  <= 1'b0;
         sda_oe_n <= 1'b1;
      end else begin
         sda_out <= 1'b0;
         if (start_det || stop_det || arb_set) begin
            sda_oe_n <= 1'b1;                                    // RULE_15
         end else if (ctrl_wr && frame == FR_ACK
                       && !transmit_direction_flag && ack_needed_flag) begin
            sda_oe_n <= !sfr_wdata[`SFL_BIT_ACK];                // RULE_05
         end else if (frame_begin) begin
            sda_oe_n <= !(data_written && !serial_byte_data[7]); // RULE_13
         end else if (live && scl_fall && frame == FR_BITS) begin
            sda_oe_n <= !(transmit_direction_flag
                          && !serial_byte_data[7]);              // RULE_14
         end else if (live && scl_fall && frame == FR_ACK) begin
            sda_oe_n <= !(!transmit_direction_flag && ack_needed_flag
                          && ack_flag);
         end
      end
   end

   // ---------------------------------------------------------------
   // Register read port
   // ---------------------------------------------------------------
   assign ctrl_byte = {master_flag, transmit_direction_flag,
                       start_request_flag, stop_request_flag,
                       ack_needed_flag, arbitration_fail_flag,
                       ack_flag, irq_flag};                      // RULE_18

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sfr_rdata <= `SFL_CTRL_RESET;
      end else if (sfr_rd && sfr_addr == `SFL_CTRL_ADDR) begin
         sfr_rdata <= ctrl_byte;
      end else if (sfr_rd && sfr_addr == `SFL_DATA_ADDR) begin
         sfr_rdata <= serial_byte_data;                          // RULE_11
      end else begin
         sfr_rdata <= 8'h00;
      end
   end

endmodule

// ==== tb/sfl_flags_assertions.sv ====
// Concurrent checks on the flag and data logic ports
`timescale 1ns/1ps
`include "sfl_cfg.svh"

module sfl_flags_assertions (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       arst_n,
   // Register port
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   // Events and pins
   input wire logic       start_generated,
   input wire logic       stop_generated,
   input wire logic       scl_low_in_cond,
   input wire logic       scl_oe_n,
   // Flags
   input wire logic       master_flag,
   input wire logic       transmit_direction_flag,
   input wire logic       start_request_flag,
   input wire logic       stop_request_flag,
   input wire logic       ack_needed_flag,
   input wire logic       arbitration_fail_flag,
   input wire logic       ack_flag,
   input wire logic       irq_flag
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   logic       clr_w;
   logic [7:0] flags;
   assign clr_w = sfr_wr && sfr_addr == `SFL_CTRL_ADDR && !sfr_wdata[0];
   assign flags = {master_flag, transmit_direction_flag,
      start_request_flag, stop_request_flag, ack_needed_flag,
      arbitration_fail_flag, ack_flag, irq_flag};
   // ------
   // Checks
   // ------
   irq_hold_a: assert property (
      irq_flag && !clr_w |=> irq_flag)
      else $error("interrupt flag dropped without a clear");
   scl_stall_a: assert property (
      irq_flag && $past(irq_flag) |-> !scl_oe_n)
      else $error("SCL released while interrupt pending");
   arb_clear_a: assert property (
      clr_w && !scl_low_in_cond |=> !arbitration_fail_flag)
      else $error("arbitration flag kept after clear");
   arb_set_a: assert property (
      scl_low_in_cond |=> arbitration_fail_flag && irq_flag && !master_flag)
      else $error("arbitration loss not flagged");
   master_set_a: assert property (
      start_generated |=> master_flag && transmit_direction_flag && irq_flag)
      else $error("generated start not flagged");
   master_clr_a: assert property (
      stop_generated && !start_generated |=> !master_flag && !stop_request_flag)
      else $error("generated stop left flags set");
   rdata_idle_a: assert property (
      !sfr_rd |=> sfr_rdata == 8'h00)
      else $error("read data not zero without read");
   rdata_ctrl_a: assert property (
      sfr_rd && sfr_addr == `SFL_CTRL_ADDR |=> sfr_rdata == $past(flags))
      else $error("control read does not match flags");
endmodule

bind sfl_flags sfl_flags_assertions u_chk (.*);

// ==== tb/sfl_bus_master.sv ====
// Bus master model driving the two-wire pins
`timescale 1ns/1ps

module sfl_bus_master (
   // Wire levels seen on the bus
   input  wire logic scl_w,
   input  wire logic sda_w,
   // Open-drain drive, 1 releases the line
   output logic      scl_drv,
   output logic      sda_drv
);
   initial begin
      scl_drv = 1'b1;
      sda_drv = 1'b1;
   end
   // SDA falls while SCL high
   task automatic start_c();
      #400 sda_drv = 1'b0;
      #400 scl_drv = 1'b0;
   endtask
   // One clock; waits while the device stretches SCL
   task automatic bit_c(input logic b, output logic s);
      #200 sda_drv = b;
      #200 scl_drv = 1'b1;
      wait (scl_w === 1'b1);
      #200 s = sda_w;
      #200 scl_drv = 1'b0;
   endtask
   // Eight bits MSB first, then a released ack slot
   task automatic xfer(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_c(d[i], s);
      end
      bit_c(1'b1, ack);
   endtask
   // SDA rises while SCL high
   task automatic stop_c();
      #200 sda_drv = 1'b0;
      #200 scl_drv = 1'b1;
      #400 sda_drv = 1'b1;
      #400;
   endtask
endmodule

// ==== tb/sfl_flags_bench.sv ====
// Self-checking bench for the flag and data logic
`timescale 1ns/1ps
`include "sfl_cfg.svh"

module sfl_flags_bench;
   localparam logic [7:0] F_MS = 8'h01 << `SFL_BIT_MASTER;
   localparam logic [7:0] F_TX = 8'h01 << `SFL_BIT_TXDIR;
   localparam logic [7:0] F_ST = 8'h01 << `SFL_BIT_START;
   localparam logic [7:0] F_SP = 8'h01 << `SFL_BIT_STOP;
   localparam logic [7:0] F_AN = 8'h01 << `SFL_BIT_ACKNEED;
   localparam logic [7:0] F_AL = 8'h01 << `SFL_BIT_ARBFAIL;
   localparam logic [7:0] F_AK = 8'h01 << `SFL_BIT_ACK;
   localparam logic [7:0] F_IR = 8'h01 << `SFL_BIT_IRQ;
   localparam logic [7:0] CA = `SFL_CTRL_ADDR;
   localparam logic [7:0] DA = `SFL_DATA_ADDR;
   logic       clk_sys, arst_n, sfr_wr, sfr_rd, addr_match, ack_s;
   logic       start_generated, stop_generated, scl_low_in_cond;
   logic [7:0] sfr_addr, sfr_wdata, rv, q[$];
   wire  [7:0] sfr_rdata;
   wire        scl_oe_n, sda_oe_n, m_scl, m_sda, scl_w, sda_w, irq_flag;
   int         fails, comparisons, cycles, seed;
   assign scl_w = m_scl & scl_oe_n;
   assign sda_w = m_sda & sda_oe_n;
   sfl_flags i_dut (
      .clk_sys (clk_sys), .arst_n (arst_n), .sfr_addr (sfr_addr),
      .sfr_wr (sfr_wr), .sfr_rd (sfr_rd), .sfr_wdata (sfr_wdata),
      .sfr_rdata (sfr_rdata), .start_generated (start_generated),
      .stop_generated (stop_generated),
      .scl_low_in_cond (scl_low_in_cond), .addr_match (addr_match),
      .scl_in (scl_w), .scl_out (), .scl_oe_n (scl_oe_n),
      .sda_in (sda_w), .sda_out (), .sda_oe_n (sda_oe_n),
      .master_flag (), .transmit_direction_flag (),
      .start_request_flag (), .stop_request_flag (),
      .ack_needed_flag (), .arbitration_fail_flag (), .ack_flag (),
      .irq_flag (irq_flag));
   sfl_bus_master i_peer (.scl_w (scl_w), .sda_w (sda_w),
      .scl_drv (m_scl), .sda_drv (m_sda));
   // -----
   // Tasks
   // -----
   task automatic end_of_test();
      $display("Counts: %0d comparisons, %0d fails", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      sfr_addr  <= a;
      sfr_wdata <= d;
      sfr_wr    <= 1'b1;
      @(posedge clk_sys);
      sfr_wr    <= 1'b0;
   endtask
   task automatic chk(input logic [7:0] a, input logic [7:0] e,
                      input logic [7:0] m);
      logic [7:0] g;
      @(posedge clk_sys);
      sfr_addr <= a;
      sfr_rd   <= 1'b1;
      @(posedge clk_sys);
      sfr_rd   <= 1'b0;
      @(negedge clk_sys);
      g = sfr_rdata;
      comparisons++;
      if ((g & m) !== (e & m)) begin
         fails++;
         $display("ERROR %0t: read %h got %h want %h", $time, a, g, e);
      end
   endtask
   // Sequencer pulses, with an optional clearing write on the same edge
   task automatic ev(input logic [2:0] e, input logic w);
      @(posedge clk_sys);
      {start_generated, stop_generated, scl_low_in_cond} <= e;
      sfr_addr  <= CA;
      sfr_wdata <= 8'h00;
      sfr_wr    <= w;
      @(posedge clk_sys);
      {start_generated, stop_generated, scl_low_in_cond} <= 3'b000;
      sfr_wr    <= 1'b0;
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      while (irq_flag !== 1'b1 && n < 2000) begin
         @(negedge clk_sys);
         n++;
      end
      comparisons++;
      if (irq_flag !== 1'b1) begin
         fails++;
         $display("ERROR %0t: interrupt flag not raised", $time);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("ERROR %0t: bus bit got %b want %b", $time, g, e);
      end
   endtask
   // --------------
   // Clock and runs
   // --------------
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 6000) begin
         fails++;
         end_of_test();
      end
   end
   initial begin
      {arst_n, sfr_wr, sfr_rd, addr_match, ack_s} = 5'b00000;
      {start_generated, stop_generated, scl_low_in_cond} = 3'b000;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      {fails, comparisons, cycles, seed} = {32'd0, 32'd0, 32'd0, 32'd42};
      repeat (4) @(posedge clk_sys);
      arst_n <= 1'b1;
      chk(CA, `SFL_CTRL_RESET, 8'hFF);
      chk(DA, `SFL_DATA_RESET, 8'hFF);
      wr(8'h55, 8'hFF);
      chk(8'h55, 8'h00, 8'hFF);
      chk(DA, 8'h00, 8'hFF);
      wr(CA, F_IR);
      chk(CA, F_IR, 8'hFF);
      rv = $random(seed);
      wr(DA, rv);
      chk(DA, rv, 8'hFF);
      wr(CA, 8'h00);
      chk(CA, 8'h00, 8'hBF);
      $display("Test registers done");
      @(posedge clk_sys);
      addr_match <= 1'b1;
      i_peer.start_c();
      for (int i = 0; i < 2; i++) begin
         rv = $random(seed);
         q.push_back(rv);
         fork
            i_peer.xfer(rv, ack_s);
            begin
               wait_irq();
               chk(CA, F_ST | F_AN | F_IR, 8'hFD);
               chk(DA, rv, 8'hFF);
               repeat (20) @(posedge clk_sys);
               chk(DA, q.pop_front(), 8'hFF);
               wr(CA, (i == 0) ? (F_ST | F_AK) : 8'h00);
            end
         join
         chk_bit(ack_s, (i == 0) ? 1'b0 : 1'b1);
         chk(CA, (i == 0) ? F_ST : 8'h00, 8'hFD);
      end
      i_peer.stop_c();
      wait_irq();
      chk(CA, F_SP | F_IR, 8'hFD);
      wr(CA, 8'h00);
      $display("Test slave receive done");
      ev(3'b100, 1'b0);
      chk(CA, F_MS | F_TX | F_IR, 8'hFD);
      ev(3'b001, 1'b1);
      chk(CA, F_AL | F_IR, 8'hFD);
      wr(CA, 8'h00);
      chk(CA, 8'h00, 8'hFD);
      ev(3'b100, 1'b1);
      chk(CA, F_MS | F_TX | F_IR, 8'hFD);
      ev(3'b010, 1'b1);
      chk(CA, 8'h00, 8'h90);
      $display("Test master events done");
      end_of_test();
   end
endmodule
